//--- hw/sgts_consts.svh
// Constants for the transfer group trigger selection block
`ifndef SGTS_CONSTS_SVH
`define SGTS_CONSTS_SVH
`define SGTS_GROUPS 8
`define SGTS_SRC_W 4
`define SGTS_EVT_W 2
`define SGTS_PORT_PINS 8
`define SGTS_TIMER_CH 6
`define SGTS_SRC_NONE 4'h0
`define SGTS_SRC_PORT_FIRST 4'h1
`define SGTS_SRC_PORT_LAST 4'h8
`define SGTS_SRC_TIMER_FIRST 4'h9
`define SGTS_SRC_TIMER_LAST 4'he
`define SGTS_SRC_TICK 4'hf
`define SGTS_SRC_COUNT 15
`endif

//--- hw/sgts_pkg.sv
// Types for the transfer group trigger selection block
`include "sgts_consts.svh"
package sgts_pkg;
    typedef enum logic [1:0] {
        SGTS_EVT_OFF = 2'b00,
        SGTS_EVT_RISE = 2'b01,
        SGTS_EVT_FALL = 2'b10,
        SGTS_EVT_LOW = 2'b11
    } sgts_evt_t;
endpackage

//--- hw/sgts_sync2.sv
// Two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module sgts_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = din;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r;
endmodule // sgts_sync2

//--- hw/sgts_trigger_select.sv
// Trigger source selection and event qualification for all transfer groups
`timescale 1ns/1ps
module sgts_trigger_select
    import sgts_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [`SGTS_PORT_PINS-1:0] generalPortAIn,
    input wire logic [`SGTS_TIMER_CH-1:0] highEndTimerOneOut,
    input wire logic tickIn,
    input wire logic [`SGTS_GROUPS*`SGTS_SRC_W-1:0] triggerSourceSelect,
    input wire logic [`SGTS_GROUPS*`SGTS_EVT_W-1:0] triggerEventSelect,
    output logic [`SGTS_GROUPS-1:0] groupTrigger,
    output logic [`SGTS_GROUPS-1:0] groupTriggerLevel
);
    localparam int NSRC = `SGTS_SRC_COUNT;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rstMeta_r;
    logic rstSync_r;
    logic rstSyncN;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    assign rstSyncN = rstSync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Source vector: index 0 is code 1. Pins are the pad value after the input
    // buffer and timers the boundary value, so no routing is needed here.
    logic [NSRC-1:0] rawSrc;
    logic [NSRC-1:0] syncSrc;

    assign rawSrc = {tickIn, highEndTimerOneOut, generalPortAIn};

    // All sources share one synchroniser so each group sees the same sample
    sgts_sync2 #(.W(NSRC)) uSync (
        .clock(clock),
        .rst_n(rstSyncN),
        .din(rawSrc),
        .dout(syncSrc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Selection
    function automatic logic selSrc(input logic [`SGTS_SRC_W-1:0] code,
                                    input logic [NSRC-1:0] v);
        logic r;
        r = 1'b0;
        if (code != `SGTS_SRC_NONE) begin
            r = v[code - `SGTS_SRC_PORT_FIRST];
        end
        return r;
    endfunction

    logic [`SGTS_GROUPS-1:0] selNow;
    logic [`SGTS_GROUPS-1:0] selPrev_r;
    logic [`SGTS_GROUPS-1:0] selPrev_nxt;
    logic [`SGTS_GROUPS-1:0] trig_r;
    logic [`SGTS_GROUPS-1:0] trig_nxt;
    logic [`SGTS_GROUPS-1:0] lvl_r;
    logic [`SGTS_GROUPS-1:0] lvl_nxt;
    logic [`SGTS_GROUPS*`SGTS_SRC_W-1:0] srcPrev_r;
    logic [`SGTS_GROUPS*`SGTS_SRC_W-1:0] srcPrev_nxt;

    always_comb begin
        selNow = '0;
        trig_nxt = '0;
        lvl_nxt = '0;
        srcPrev_nxt = triggerSourceSelect;
        for (int g = 0; g < `SGTS_GROUPS; g++) begin
            sgts_evt_t ev;
            logic chg;
            ev = sgts_evt_t'(triggerEventSelect[g*`SGTS_EVT_W +: `SGTS_EVT_W]);
            // A change of source must not look like an edge
            chg = triggerSourceSelect[g*`SGTS_SRC_W +: `SGTS_SRC_W]
                != srcPrev_r[g*`SGTS_SRC_W +: `SGTS_SRC_W];
            selNow[g] = selSrc(triggerSourceSelect[g*`SGTS_SRC_W +: `SGTS_SRC_W],
                               syncSrc);
            if (triggerSourceSelect[g*`SGTS_SRC_W +: `SGTS_SRC_W] != `SGTS_SRC_NONE) begin
                unique case (ev)
                    SGTS_EVT_OFF: begin
                        trig_nxt[g] = 1'b0;
                    end
                    SGTS_EVT_RISE: begin
                        trig_nxt[g] = selNow[g] & ~selPrev_r[g] & ~chg;
                    end
                    SGTS_EVT_FALL: begin
                        trig_nxt[g] = ~selNow[g] & selPrev_r[g] & ~chg;
                    end
                    SGTS_EVT_LOW: begin
                        trig_nxt[g] = ~selNow[g];
                        lvl_nxt[g] = ~selNow[g];
                    end
                endcase
            end
        end
        selPrev_nxt = selNow;
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            selPrev_r <= '0;
            trig_r <= '0;
            lvl_r <= '0;
            srcPrev_r <= '0;
        end else begin
            selPrev_r <= selPrev_nxt;
            trig_r <= trig_nxt;
            lvl_r <= lvl_nxt;
            srcPrev_r <= srcPrev_nxt;
        end
    end

    assign groupTrigger = trig_r;
    assign groupTriggerLevel = lvl_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_none_never_fires;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerSourceSelect[3:0] == `SGTS_SRC_NONE) |=> !groupTrigger[0];
    endproperty
    a_none_never_fires: assert property (p_none_never_fires)
        else $error("group 0 fired with no source");

    property p_none_level;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerSourceSelect[31:28] == `SGTS_SRC_NONE) |=> !groupTriggerLevel[7];
    endproperty
    a_none_level: assert property (p_none_level)
        else $error("group 7 held a level with no source");

    property p_rise_fires;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerEventSelect[3:2] == SGTS_EVT_RISE && $stable(triggerSourceSelect[7:4])
         && triggerSourceSelect[7:4] == 4'h1 && $rose(syncSrc[0])) |=> groupTrigger[1];
    endproperty
    a_rise_fires: assert property (p_rise_fires)
        else $error("rising edge on pin 0 missed");

    property p_fall_fires;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerEventSelect[5:4] == SGTS_EVT_FALL && $stable(triggerSourceSelect[11:8])
         && triggerSourceSelect[11:8] == 4'h3 && $fell(syncSrc[2])) |=> groupTrigger[2];
    endproperty
    a_fall_fires: assert property (p_fall_fires)
        else $error("falling edge on pin 2 missed");

    // Reselecting a source must not start a group on the jump between sources
    property p_reselect_quiet;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerEventSelect[3:2] == SGTS_EVT_RISE && !$stable(triggerSourceSelect[7:4]))
        |=> !groupTrigger[1];
    endproperty
    a_reselect_quiet: assert property (p_reselect_quiet)
        else $error("group 1 fired on a change of source");

    property p_low_level;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerEventSelect[11:10] == SGTS_EVT_LOW && triggerSourceSelect[23:20] == 4'hf
         && !syncSrc[14]) |=> groupTriggerLevel[5];
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("low level on tick not seen");

    // The synchroniser refills for two edges after reset, so history starts later
    property p_timer_map;
        @(posedge clock) disable iff (!rstSyncN)
        ($past(rstSyncN, 2) && triggerSourceSelect[19:16] == 4'h9
         && triggerEventSelect[9:8] == SGTS_EVT_LOW)
        |=> groupTrigger[4] != $past(highEndTimerOneOut[0], 3);
    endproperty
    a_timer_map: assert property (p_timer_map)
        else $error("timer code 9 mapped wrongly");

    property p_sync_delay;
        @(posedge clock) disable iff (!rstSyncN)
        $past(rstSyncN, 2) |-> syncSrc == $past(rawSrc, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("source not two stages late");

    property p_pulse_one;
        @(posedge clock) disable iff (!rstSyncN)
        (groupTrigger[3] && triggerEventSelect[7:6] == SGTS_EVT_RISE
         && $stable(triggerEventSelect[7:6])) |=> !groupTrigger[3];
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("edge trigger longer than one cycle");

    property p_off_quiet;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerEventSelect[13:12] == SGTS_EVT_OFF) |=> !groupTrigger[6];
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("disabled group fired");

    property p_port_pin;
        @(posedge clock) disable iff (!rstSyncN)
        (triggerSourceSelect[27:24] == 4'h8 && triggerEventSelect[13:12] == SGTS_EVT_LOW
         && !syncSrc[7]) |=> groupTrigger[6];
    endproperty
    a_port_pin: assert property (p_port_pin)
        else $error("port pin 7 low not seen");

    c_rise: cover property (@(posedge clock) disable iff (!rstSyncN) $rose(groupTrigger[0]));
    c_level: cover property (@(posedge clock) disable iff (!rstSyncN) groupTriggerLevel[5]);
    c_fall: cover property (@(posedge clock) disable iff (!rstSyncN) $rose(groupTrigger[2]));
    c_timer: cover property (@(posedge clock) disable iff (!rstSyncN) groupTrigger[4]);
    c_all: cover property (@(posedge clock) disable iff (!rstSyncN) &groupTrigger);
endmodule // sgts_trigger_select

//--- test/sgts_far_model.sv
// Far-side stand-in: port A pads, timer channel outputs and the tick counter
`timescale 1ns/1ps
module sgts_far_model (
    input wire logic [14:0] srcDrive,
    output logic [7:0] portPad,
    output logic [5:0] timerOut,
    output logic tick
);
    // Pad value after the input buffer; it is the same whoever drives the pin
    assign portPad = srcDrive[7:0];
    // Taken at the timer boundary, so it toggles even when the pad is not routed
    assign timerOut = srcDrive[13:8];
    assign tick = srcDrive[14];
endmodule // sgts_far_model

//--- test/sgts_trigger_select_tb.sv
// Self-checking bench for the transfer group trigger selection block
`timescale 1ns/1ps
module sgts_trigger_select_tb;
    import sgts_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [14:0] srcDrive = 15'h0000;
    logic [31:0] srcSel = 32'h0;
    logic [15:0] evtSel = 16'h0;
    logic [7:0] portPad;
    logic [5:0] timerOut;
    logic tick;
    logic [7:0] groupTrigger;
    logic [7:0] groupTriggerLevel;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    sgts_far_model far (.srcDrive(srcDrive), .portPad(portPad), .timerOut(timerOut),
        .tick(tick));
    sgts_trigger_select dut (.clock(clock), .rst_n(rst_n), .generalPortAIn(portPad),
        .highEndTimerOneOut(timerOut), .tickIn(tick), .triggerSourceSelect(srcSel),
        .triggerEventSelect(evtSel), .groupTrigger(groupTrigger),
        .groupTriggerLevel(groupTriggerLevel));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Sources settle before the select changes, so no stale edge meets the new code
    task automatic trial(input int g, input logic [3:0] code, input sgts_evt_t evt,
        input logic v0, input logic v1, input logic fire);
        logic [7:0] m;
        logic [31:0] s;
        logic [15:0] e;
        m = fire ? (8'h01 << g) : 8'h00;
        s = 32'h0;
        e = 16'h0;
        s[4*g +: 4] = code;
        e[2*g +: 2] = evt;
        @(negedge clock);
        // Triggers go off before the pads move, since a pin given away still reaches them
        srcSel = 32'h0;
        srcDrive = {15{v0}};
        repeat (3) @(negedge clock);
        srcSel = s;
        evtSel = e;
        repeat (5) @(negedge clock);
        check(groupTrigger, 8'h00);
        if (code == 4'h0) srcDrive = {15{v1}};
        else srcDrive[code - 4'h1] = v1;
        repeat (3) @(negedge clock);
        check(groupTrigger, m);
        check(groupTriggerLevel, (evt == SGTS_EVT_LOW) ? m : 8'h00);
        @(negedge clock);
        check(groupTrigger, (evt == SGTS_EVT_LOW) ? m : 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic scenAllSources();
        for (int c = 1; c <= 15; c++) begin
            trial(c % 8, c[3:0], SGTS_EVT_RISE, 1'b0, 1'b1, 1'b1);
        end
    endtask
    task automatic scenEventModes();
        trial(2, 4'h3, SGTS_EVT_FALL, 1'b1, 1'b0, 1'b1);
        trial(1, 4'h2, SGTS_EVT_RISE, 1'b1, 1'b0, 1'b0);
        trial(4, 4'h9, SGTS_EVT_LOW, 1'b1, 1'b0, 1'b1);
        trial(5, 4'hf, SGTS_EVT_LOW, 1'b1, 1'b0, 1'b1);
        trial(6, 4'h5, SGTS_EVT_OFF, 1'b0, 1'b1, 1'b0);
        trial(6, 4'h8, SGTS_EVT_LOW, 1'b1, 1'b0, 1'b1);
    endtask
    task automatic scenDisabled();
        trial(0, 4'h0, SGTS_EVT_RISE, 1'b0, 1'b1, 1'b0);
        trial(7, 4'h0, SGTS_EVT_LOW, 1'b1, 1'b0, 1'b0);
    endtask
    // Two groups share one pin with different events; a third watches another pin
    task automatic scenIndependent();
        @(negedge clock);
        srcDrive = 15'h0000;
        repeat (3) @(negedge clock);
        srcSel = 32'h2000_0021;
        evtSel = 16'h4009;
        repeat (5) @(negedge clock);
        srcDrive[1] = 1'b1;
        repeat (3) @(negedge clock);
        check(groupTrigger, 8'h80);
        srcDrive[1] = 1'b0;
        repeat (3) @(negedge clock);
        check(groupTrigger, 8'h02);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        scenAllSources();
        scenEventModes();
        scenDisabled();
        scenIndependent();
        end_sim();
    end
endmodule // sgts_trigger_select_tb
